/* rtl/external_bus_dynamic_sizing.sv */
// External bus master with dynamic port sizing, byte steering and operand splitting.
// Assumes one 50 MHz clock; acknowledge and autovector pins come asynchronously from outside.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module external_bus_dynamic_sizing #(
	parameter int WAIT_W = 4
)(
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    reset_i,
	// Operand request from the core
	input  wire logic                    req_valid_i,
	input  wire ext_bus_pkg::op_req_s    req_i,
	input  wire logic [WAIT_W-1:0]       fast_waits_i,
	input  wire logic                    other_master_i,
	output logic                         req_ready_o,
	output logic                         done_o,
	output logic                         misaligned_o,
	output logic                         autovector_o,
	output logic [31:0]                  rdata_o,
	// External bus pins
	input  wire logic [1:0]              data_size_ack_n_i,
	input  wire logic                    autovector_request_n_i,
	input  wire logic [15:0]             data_i,
	output ext_bus_pkg::bus_out_s        bus_o
);
	initial
	begin
		if (WAIT_W < 1 || WAIT_W > 16)
			$error("WAIT_W out of range");
	end

	ext_bus_pkg::bus_state_e state;
	ext_bus_pkg::op_req_s    op;
	logic [1:0]              ack_s1;
	logic [1:0]              ack;
	logic                    autovector_request_s1;
	logic                    autovector_request;
	logic [2:0]              left;
	logic [1:0]              clocks;
	logic [WAIT_W-1:0]       waits;
	logic [31:0]             rbuf;
	logic [23:0]             next_addr_hold;
	logic [2:0]              total;

	function automatic logic [1:0] size_code(input logic [2:0] n);
		case (n)
			3'h1:    size_code = `SIZE_BYTE;
			3'h2:    size_code = `SIZE_WORD;
			3'h3:    size_code = `SIZE_THREE;
			default: size_code = `SIZE_LONG;
		endcase
	endfunction : size_code

	function automatic logic [2:0] size_bytes(input logic [1:0] c);
		case (c)
			`SIZE_BYTE:  size_bytes = 3'h1;
			`SIZE_WORD:  size_bytes = 3'h2;
			`SIZE_THREE: size_bytes = 3'h3;
			default:     size_bytes = 3'h4;
		endcase
	endfunction : size_bytes

	// Acknowledge decode; reserved code is treated as a wait, the cycle never ends on it.
	wire ack_port8  = (ack == `ACK_PORT8);                                      // R05 R08
	wire ack_port16 = (ack == `ACK_PORT16);                                     // R05 R09
	wire ack_done   = ack_port8 || ack_port16;
	// Autovector only counts in an interrupt acknowledge while we own the bus.
	wire autovector_request_ok    = op.intack && !autovector_request && !other_master_i;                    // R01 R02 R03 R04
	wire cur_odd    = op.addr[0];
	wire [2:0] req_bytes = size_bytes(req_i.size);
	wire req_bad    = req_i.size != `SIZE_BYTE && req_i.addr[0];               // R13
	// Bytes moved this cycle: a 16-bit port moves an aligned word at most.
	wire [2:0] moved = ack_port8 || left == 3'h1 || cur_odd ? 3'h1 : 3'h2;      // R10 R14 R15
	wire [2:0] next_left = left - moved;
	wire [23:0] next_addr = op.addr + 24'(moved);                              // R12
	// Byte lane of the current single byte read: lower lane only for odd address at 16-bit.
	wire byte_lo    = ack_port16 && cur_odd;                                    // R16
	wire [7:0] byte_in = byte_lo ? data_i[7:0] : data_i[15:8];                  // R19
	// Operand byte index of the first byte moved this cycle, most significant first.
	// The size code is rewritten per portion, so the index counts from the original length.
	wire [1:0] op_idx = 2'(total - left);                                      // R11
	wire [31:0] wshift = op.wdata << {op_idx, 3'h0};
	wire [7:0] wb0  = wshift[31:24];
	wire [7:0] wb1  = wshift[23:16];
	// A single-byte portion goes on both lanes so either port width takes it.
	wire [15:0] wlanes = (left == 3'h1 || cur_odd) ? {wb0, wb0} : {wb0, wb1};   // R25 R26

	// Synchronisers for the acknowledge and autovector pins.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ack_s1  <= `ACK_WAIT;
			ack     <= `ACK_WAIT;
			autovector_request_s1 <= 1'b1;
			autovector_request    <= 1'b1;
		end
		else
		begin
			ack_s1  <= data_size_ack_n_i;
			ack     <= ack_s1;
			autovector_request_s1 <= autovector_request_n_i;
			autovector_request    <= autovector_request_s1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state        <= ext_bus_pkg::ST_IDLE;
			op           <= '0;
			left         <= 3'h0;
			total        <= 3'h0;
			clocks       <= 2'h0;
			waits        <= '0;
			rbuf         <= '0;
			req_ready_o  <= 1'b1;
			done_o       <= 1'b0;
			misaligned_o <= 1'b0;
			autovector_o <= 1'b0;
			rdata_o      <= '0;
			bus_o        <= '0;
		end
		else
		begin
			done_o       <= 1'b0;
			misaligned_o <= 1'b0;
			autovector_o <= 1'b0;
			unique case (state)
				ext_bus_pkg::ST_IDLE:
				begin
					if (req_valid_i && req_bad)
						misaligned_o <= 1'b1;                              // R13
					else if (req_valid_i)
					begin
						op          <= req_i;
						left        <= req_bytes;
						total       <= req_bytes;
						rbuf        <= '0;
						clocks      <= 2'h1;
						waits       <= fast_waits_i;
						req_ready_o <= 1'b0;
						if (req_i.internal)
							state <= ext_bus_pkg::ST_INT;                  // R22
						else
						begin
							bus_o.addr    <= req_i.addr;                   // R12
							bus_o.size    <= req_i.size;                   // R10 R24
							bus_o.write   <= req_i.write;
							bus_o.intack  <= req_i.intack;
							bus_o.strobe  <= 1'b1;
							state <= req_i.fast ? ext_bus_pkg::ST_FAST
							                    : ext_bus_pkg::ST_ADDR;
						end
					end
				end
				ext_bus_pkg::ST_INT:
				begin
					done_o      <= 1'b1;                                  // R22
					req_ready_o <= 1'b1;
					state       <= ext_bus_pkg::ST_IDLE;
				end
				ext_bus_pkg::ST_ADDR:
				begin
					// Strobe drops for one clock between portions; through the two-stage synchronisers the last acknowledge can still end the next wait.
					bus_o.strobe  <= 1'b1;
					bus_o.data    <= wlanes;                               // R25 R26
					bus_o.data_oe <= op.write;
					clocks        <= clocks + 2'h1;
					if (clocks + 2'h1 == 2'(`EXT_CYCLE_CLOCKS - 1))
						state <= ext_bus_pkg::ST_WAIT;                     // R21
				end
				ext_bus_pkg::ST_FAST:
				begin
					bus_o.strobe  <= 1'b1;
					bus_o.data    <= wlanes;
					bus_o.data_oe <= op.write;
					// Programmed waits run down before the internal acknowledge.
					if (waits != '0)
						waits <= waits - 1'b1;                             // R23
					else
					begin
						if (!op.write)
							rbuf <= {rbuf[15:0], data_i};
						state <= ext_bus_pkg::ST_DONE;
					end
				end
				ext_bus_pkg::ST_WAIT:
				begin
					if (autovector_request_ok)
					begin
						autovector_o <= 1'b1;                              // R01 R03
						left  <= 3'h0;
						state <= ext_bus_pkg::ST_DONE;
					end
					else if (ack_done)                                     // R21
					begin
						if (!op.write && moved == 3'h1)
							rbuf <= {rbuf[23:0], byte_in};                 // R07 R16 R19
						else if (!op.write)
							rbuf <= {rbuf[15:0], data_i};                  // R06 R09
						left  <= next_left;
						state <= ext_bus_pkg::ST_DONE;
					end
				end
				ext_bus_pkg::ST_DONE:
				begin
					bus_o.strobe  <= 1'b0;
					bus_o.data_oe <= 1'b0;
					if (op.fast && left != 3'h0)
						left <= 3'h0 + ((left > 3'h2) ? left - 3'h2 : 3'h0); // R14 R18
					if ((op.fast ? (left > 3'h2) : (left != 3'h0)))
					begin
						// Next cycle: size shows what is still outstanding.
						op.addr      <= op.fast ? op.addr + 24'h2 : next_addr_hold;
						op.size      <= size_code(op.fast ? left - 3'h2 : left); // R15 R17 R20
						bus_o.addr   <= op.fast ? op.addr + 24'h2 : next_addr_hold;
						bus_o.size   <= size_code(op.fast ? left - 3'h2 : left);
						clocks       <= 2'h1;
						waits        <= fast_waits_i;
						state <= op.fast ? ext_bus_pkg::ST_FAST : ext_bus_pkg::ST_ADDR;
					end
					else
					begin
						done_o      <= 1'b1;
						rdata_o     <= rbuf;
						req_ready_o <= 1'b1;
						state       <= ext_bus_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Address for the next portion is captured when the acknowledge is taken.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			next_addr_hold <= '0;
		else if (state == ext_bus_pkg::ST_WAIT && ack_done)
			next_addr_hold <= next_addr;
	end

	sequence cycle_start;
		state == ext_bus_pkg::ST_IDLE && req_valid_i && !req_bad && !req_i.internal
			&& !req_i.fast;
	endsequence

	ext_min_three_a: assert property (@(posedge clk_i) disable iff (reset_i) // R21
		cycle_start |=> !done_o [*3])
		else $error("external cycle ended in under three clocks");
	int_two_clk_a: assert property (@(posedge clk_i) disable iff (reset_i) // R22
		state == ext_bus_pkg::ST_IDLE && req_valid_i && req_i.internal && !req_bad
			|=> ##1 done_o)
		else $error("internal access not two clocks");
	autovector_request_ignored_a: assert property (@(posedge clk_i) disable iff (reset_i) // R02
		autovector_o |-> op.intack)
		else $error("autovector outside interrupt acknowledge");
	autovector_request_master_a: assert property (@(posedge clk_i) disable iff (reset_i) // R04
		state == ext_bus_pkg::ST_WAIT && other_master_i |=> !autovector_o)
		else $error("autovector while another master owns bus");
	misalign_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // R13
		state == ext_bus_pkg::ST_IDLE && req_valid_i && req_bad |=> misaligned_o
			&& req_ready_o)
		else $error("misaligned request not refused");
	start_size_a: assert property (@(posedge clk_i) disable iff (reset_i) // R10
		cycle_start |=> bus_o.size == $past(req_i.size) && bus_o.strobe)
		else $error("first cycle size not full operand");
	three_code_a: assert property (@(posedge clk_i) disable iff (reset_i) // R20
		bus_o.strobe && bus_o.size == `SIZE_THREE |-> bus_o.addr[0])
		else $error("three-byte code at even address");
	write_dup_a: assert property (@(posedge clk_i) disable iff (reset_i) // R26
		bus_o.data_oe && bus_o.size == `SIZE_BYTE |-> bus_o.data[15:8] == bus_o.data[7:0])
		else $error("byte write not duplicated");
endmodule : external_bus_dynamic_sizing

/* rtl/ext_bus_defines.svh */
// Constants for the external bus sizing unit: size codes, acknowledge codes, cycle counts.
// Assumes a single 50 MHz system clock; included by the design.
// Functional notes
// [R01] Autovector request ends interrupt acknowledge cycles
// [R02] Autovector request ignored outside interrupt acknowledge
// [R03] Held autovector request autovectors every acknowledge
// [R04] Autovector disabled while another master owns bus
// [R05] Acknowledge pair: wait, 8-bit, 16-bit, reserved
// [R06] Long read at 16-bit: latch, second cycle
// [R07] Long read at 8-bit: four byte cycles
// [R08] Peripheral always reports its fixed port width
// [R09] 16-bit port on all lanes, 8-bit upper
// [R10] Every cycle starts assuming a 16-bit port
// [R11] Operand bytes move most significant first
// [R12] Address carries word base plus byte offset
// [R13] Odd word or long word is refused
// [R14] At most one aligned word per cycle
// [R15] Size outputs give bytes still outstanding
// [R16] Byte lane chosen by offset and port width
// [R17] Long to 8-bit: long, three, word, byte
// [R18] Long to 16-bit: long code, then word
// [R19] Unrequested lanes are ignored on reads
// [R20] Three-byte code only continues long-to-8-bit
// [R21] External cycle three clocks plus wait states
// [R22] Internal access completes in two clocks
// [R23] Fast termination: two clocks plus programmed waits
// [R24] Size codes: 01 byte, 10 word, 11 three, 00 long
// [R25] Writes drive all sixteen data lines
// [R26] Byte-wide write portion duplicated on both lanes
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define SIZE_BYTE        2'h1
`define SIZE_WORD        2'h2
`define SIZE_THREE       2'h3
`define SIZE_LONG        2'h0
`define ACK_WAIT         2'h3
`define ACK_PORT8        2'h2
`define ACK_PORT16       2'h1
`define ACK_RESERVED     2'h0
`define EXT_CYCLE_CLOCKS 3
`define INT_CYCLE_CLOCKS 2
`define FAST_CYCLE_CLOCKS 2
`endif

/* rtl/ext_bus_pkg.sv */
// Types for the external bus sizing unit.
// Assumes ext_bus_defines.svh is on the include path.
package ext_bus_pkg;
	typedef enum logic [5:0]
	{
		ST_IDLE   = 6'h01,
		ST_ADDR   = 6'h02,
		ST_WAIT   = 6'h04,
		ST_DONE   = 6'h08,
		ST_FAST   = 6'h10,
		ST_INT    = 6'h20
	} bus_state_e;

	typedef struct packed
	{
		logic [23:0] addr;
		logic [1:0]  size;
		logic        write;
		logic        intack;
		logic        internal;
		logic        fast;
		logic [31:0] wdata;
	} op_req_s;

	typedef struct packed
	{
		logic [23:0] addr;
		logic [1:0]  size;
		logic        write;
		logic        intack;
		logic        strobe;
		logic [15:0] data;
		logic        data_oe;
	} bus_out_s;
endpackage : ext_bus_pkg

/* dv/ext_mem_model.sv */
// Behavioural external memory that answers bus cycles with a chosen port width and wait count.
// Assumes the master holds strobe until it has seen the acknowledge.
`timescale 1ns/1ps
module ext_mem_model (
	// Clock
	input  wire logic                  clk_i,
	// Bus from the master
	input  wire ext_bus_pkg::bus_out_s bus_i,
	// Behaviour controls
	input  wire logic                  port8_i,
	input  wire logic [3:0]            waits_i,
	input  wire logic                  mute_i,
	// Answer to the master
	output logic [1:0]                 ack_n_o,
	output logic [15:0]                data_o
);
	logic [3:0]  cnt = 4'h0;
	logic [15:0] junk = 16'h0;
	wire  [23:0] even_addr = {bus_i.addr[23:1], 1'b0};
	wire  [7:0]  even_byte = even_addr[7:0] ^ 8'h5a;
	wire  [7:0]  odd_byte = {even_addr[7:1], 1'b1} ^ 8'h5a;
	wire  [7:0]  own_byte = bus_i.addr[7:0] ^ 8'h5a;
	wire         answer = bus_i.strobe && cnt >= waits_i && !mute_i;

	// Released lanes carry a changing pattern so that a stale value can never pass.
	always @(posedge clk_i)
	begin
		junk <= junk + 16'h3b1d;
		cnt <= bus_i.strobe ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
	end

	assign ack_n_o = !answer ? 2'b11 : (port8_i ? 2'b10 : 2'b01);
	assign data_o = (!bus_i.strobe || bus_i.write) ? junk :
		(port8_i ? {own_byte, junk[7:0]} : {even_byte, odd_byte});
endmodule : ext_mem_model

/* dv/external_bus_dynamic_sizing_test.sv */
// Self-checking bench for the external bus sizing unit against a behavioural memory.
// Assumes the package, the design and ext_mem_model are compiled first.
`timescale 1ns/1ps
module external_bus_dynamic_sizing_test;
	logic                  clk_i = 1'b0;
	logic                  reset_i = 1'b1;
	logic                  req_valid_i = 1'b0;
	ext_bus_pkg::op_req_s  req_i = '0;
	logic [3:0]            fast_waits_i = 4'h0;
	logic                  other_master_i = 1'b0;
	logic                  autovector_request_n = 1'b1;
	logic                  port8 = 1'b0;
	logic                  mute = 1'b0;
	logic [3:0]            waits = 4'h0;
	logic                  req_ready_o, done_o, misaligned_o, autovector_o;
	logic [31:0]           rdata_o;
	logic [1:0]            ack_n;
	logic [15:0]           data_i;
	ext_bus_pkg::bus_out_s bus_o, prev;
	logic [42:0]           cyc[$];
	int                    err_total = 0;
	int                    cmp_count = 0;
	int                    n;
	logic                  av, mis;

	external_bus_dynamic_sizing u_external_bus_dynamic_sizing (.clk_i(clk_i), .reset_i(reset_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .fast_waits_i(fast_waits_i),
		.other_master_i(other_master_i), .req_ready_o(req_ready_o), .done_o(done_o),
		.misaligned_o(misaligned_o), .autovector_o(autovector_o), .rdata_o(rdata_o),
		.data_size_ack_n_i(ack_n), .autovector_request_n_i(autovector_request_n), .data_i(data_i),
		.bus_o(bus_o));
	ext_mem_model u_ext_mem_model (.clk_i(clk_i), .bus_i(bus_o), .port8_i(port8),
		.waits_i(waits), .mute_i(mute), .ack_n_o(ack_n), .data_o(data_i));

	always #10 clk_i = ~clk_i;

	// Each finished bus cycle is logged as it closes, with data_oe, size, address and data.
	always @(posedge clk_i)
	begin
		prev <= bus_o;
		if (prev.strobe && !bus_o.strobe)
			cyc.push_back({prev.data_oe, prev.size, prev.addr, prev.data});
	end

	function automatic logic [7:0] mb(input logic [23:0] x);
		return x[7:0] ^ 8'h5a;
	endfunction : mb

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc_chk(input int i, input logic [1:0] sz, input logic [23:0] a,
		input logic [15:0] d, input logic [15:0] m);
		check("cycle logged", 32'(cyc.size() > i), 32'h1);
		check("size", 32'(cyc[i][41:40]), 32'(sz));
		check("addr", 32'(cyc[i][39:16]), 32'(a));
		check("data", 32'(cyc[i][15:0] & m), 32'(d & m));
		check("data_oe", 32'(cyc[i][42]), 32'(m != 16'h0));
	endtask : cyc_chk

	// Kind bits are write, interrupt acknowledge, internal and fast, from the top.
	task automatic run_op(input logic [23:0] a, input logic [1:0] sz, input logic [3:0] kind,
		input logic [31:0] wd);
		cyc.delete();
		av = 1'b0;
		mis = 1'b0;
		@(posedge clk_i);
		#1;
		while (req_ready_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_i <= '{addr:a, size:sz, write:kind[3], intack:kind[2], internal:kind[1],
			fast:kind[0], wdata:wd};
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		#1;
		n = 0;
		av |= autovector_o;
		mis |= misaligned_o;
		while (done_o !== 1'b1 && misaligned_o !== 1'b1 && n < 300)
		begin
			@(posedge clk_i);
			#1;
			n++;
			av |= autovector_o;
			mis |= misaligned_o;
		end
		check("finished", 32'(n < 300), 32'h1);
		repeat (3) @(posedge clk_i);
	endtask : run_op

	task automatic t_port16;
		port8 <= 1'b0;
		waits <= 4'h0;
		run_op(24'h000100, 2'h0, 4'h0, 32'h0);
		cyc_chk(0, 2'h0, 24'h000100, 16'h0, 16'h0);
		cyc_chk(1, 2'h2, 24'h000102, 16'h0, 16'h0);
		check("rdata", rdata_o, {mb(24'h100), mb(24'h101), mb(24'h102), mb(24'h103)});
		run_op(24'h000200, 2'h0, 4'h8, 32'h11223344);
		cyc_chk(0, 2'h0, 24'h000200, 16'h1122, 16'hffff);
		cyc_chk(1, 2'h2, 24'h000202, 16'h3344, 16'hffff);
		run_op(24'h000301, 2'h1, 4'h0, 32'h0);
		check("byte odd", 32'(rdata_o[7:0]), 32'(mb(24'h301)));
		run_op(24'h000303, 2'h1, 4'h8, 32'hc3000000);
		cyc_chk(0, 2'h1, 24'h000303, 16'hc3c3, 16'hffff);
		$display("port16 done");
	endtask : t_port16

	task automatic t_port8;
		port8 <= 1'b1;
		waits <= 4'h3;
		run_op(24'h000104, 2'h0, 4'h0, 32'h0);
		for (int i = 0; i < 4; i++)
			cyc_chk(i, 2'(4 - i), 24'h000104 + 24'(i), 16'h0, 16'h0);
		check("rdata", rdata_o, {mb(24'h104), mb(24'h105), mb(24'h106), mb(24'h107)});
		run_op(24'h000204, 2'h0, 4'h8, 32'ha1b2c3d4);
		for (int i = 0; i < 4; i++)
			cyc_chk(i, 2'(4 - i), 24'h000204 + 24'(i), {8'ha1 + 8'(i * 8'h11), 8'h0}, 16'hff00);
		run_op(24'h000400, 2'h2, 4'h0, 32'h0);
		cyc_chk(1, 2'h1, 24'h000401, 16'h0, 16'h0);
		check("word", 32'(rdata_o[15:0]), {16'h0, mb(24'h400), mb(24'h401)});
		run_op(24'h000300, 2'h1, 4'h0, 32'h0);
		check("byte", 32'(rdata_o[7:0]), 32'(mb(24'h300)));
		$display("port8 done");
	endtask : t_port8

	task automatic t_refuse;
		for (int s = 0; s < 3; s += 2)
		begin
			run_op(24'h000401, 2'(s), 4'h0, 32'h0);
			check("misaligned", 32'(mis), 32'h1);
			check("no cycle", 32'(cyc.size()), 32'h0);
		end
		$display("refuse done");
	endtask : t_refuse

	task automatic t_autovector_request;
		mute <= 1'b1;
		autovector_request_n <= 1'b0;
		repeat (2)
		begin
			run_op(24'h000011, 2'h1, 4'h4, 32'h0);
			check("autovector", 32'(av), 32'h1);
		end
		mute <= 1'b0;
		run_op(24'h000500, 2'h1, 4'h0, 32'h0);
		check("ignored", 32'(av), 32'h0);
		check("rdata", 32'(rdata_o[7:0]), 32'(mb(24'h500)));
		other_master_i <= 1'b1;
		run_op(24'h000011, 2'h1, 4'h4, 32'h0);
		check("disabled", 32'(av), 32'h0);
		other_master_i <= 1'b0;
		autovector_request_n <= 1'b1;
		$display("autovector done");
	endtask : t_autovector_request

	task automatic t_fast;
		mute <= 1'b1;
		run_op(24'h000600, 2'h2, 4'h2, 32'h0);
		check("internal time", 32'(n <= 3), 32'h1);
		fast_waits_i <= 4'h2;
		run_op(24'h000602, 2'h2, 4'h1, 32'h0);
		check("fast time", 32'(n <= 6), 32'h1);
		mute <= 1'b0;
		$display("fast done");
	endtask : t_fast

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	initial
	begin
		#400000;
		err_total++;
		print_verdict();
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		t_port16();
		t_port8();
		t_refuse();
		t_autovector_request();
		t_fast();
		print_verdict();
	end
endmodule : external_bus_dynamic_sizing_test
